// >>> dv/rcr_ctrl_sva.sv
`timescale 1ns/1ps
module rcr_ctrl_chk (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic [6:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic [15:0] rec_left_out,
	input wire logic [15:0] rec_right_out,
	input wire logic        rec_out_valid,
	input wire logic [5:0]  input_gain_left,
	input wire logic        record_converter_off,
	input wire logic        record_analog_off,
	input wire logic        reference_buffer_off,
	input wire logic        record_master_en,
	input wire logic        master_out_en,
	input wire logic        pll_ref_en,
	input wire logic        third_clock_from_receiver,
	input wire logic        third_system_clock_rate
);
	// Shadows of the control registers; q counts quiet cycles so that
	// steady-state checks skip the settling window after any write.
	logic [7:0] sh1, sh2, shp, next_sh1, next_sh2, next_shp;
	logic [2:0] q, next_q;
	always_comb begin
		next_sh1 = sh1;
		next_sh2 = sh2;
		next_shp = shp;
		next_q = (q == 3'h7) ? q : q + 3'h1;
		if (reg_wr) begin
			next_q = 3'h0;
			if (reg_addr == rcr_pkg::OFS_RECORD_CONTROL_ONE)
				next_sh1 = reg_wdata;
			if (reg_addr == rcr_pkg::OFS_RECORD_CONTROL_TWO)
				next_sh2 = reg_wdata;
			if (reg_addr == rcr_pkg::OFS_PLL_CLOCK_CONTROL)
				next_shp = reg_wdata;
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sh1 <= 8'h00;
			sh2 <= 8'h00;
			shp <= 8'h00;
			q <= 3'h0;
		end else begin
			sh1 <= next_sh1;
			sh2 <= next_sh2;
			shp <= next_shp;
			q <= next_q;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	property p_gain;
		reg_wr && reg_addr == rcr_pkg::OFS_ADC_LEFT_GAIN |-> ##2 input_gain_left ==
		(($past(reg_wdata[5:0], 2) > 6'h30) ? 6'h30 : $past(reg_wdata[5:0], 2));
	endproperty
	a_gain: assert property (p_gain) else $error("gain code not clamped");
	property p_ana;
		reg_wr && reg_addr == rcr_pkg::OFS_RECORD_CONTROL_ONE |->
		##2 {record_converter_off, record_analog_off} == $past(reg_wdata[5:4], 2);
	endproperty
	a_ana: assert property (p_ana) else $error("power-down bits wrong");
	property p_buf;
		reg_wr && reg_addr == rcr_pkg::OFS_RECORD_CONTROL_TWO |->
		##2 reference_buffer_off == $past(reg_wdata[4], 2);
	endproperty
	a_buf: assert property (p_buf) else $error("buffer power-down wrong");
	property p_mute;
		rec_out_valid && q == 3'h7 |-> (!sh1[2] || rec_left_out == 16'h0000) &&
		(!sh1[3] || rec_right_out == 16'h0000);
	endproperty
	a_mute: assert property (p_mute) else $error("muted channel not silent");
	property p_div;
		q == 3'h7 && sh2[1:0] inside {2'h0, 2'h3} |-> record_master_en;
	endproperty
	a_div: assert property (p_div) else $error("divide by one gap");
	property p_route;
		reg_wr && reg_addr == rcr_pkg::OFS_PLL_CLOCK_CONTROL |->
		##2 third_clock_from_receiver == ($past(reg_wdata[7:6], 2) == 2'h3);
	endproperty
	a_route: assert property (p_route) else $error("clock route wrong");
	property p_moh;
		q == 3'h7 |-> (shp[5] ? master_out_en != $past(master_out_en) : master_out_en);
	endproperty
	a_moh: assert property (p_moh) else $error("master out rate wrong");
	property p_pre;
		q == 3'h7 |-> (shp[4] ? pll_ref_en != $past(pll_ref_en) : pll_ref_en);
	endproperty
	a_pre: assert property (p_pre) else $error("pll reference rate wrong");
	property p_rate;
		reg_wr && reg_addr == rcr_pkg::OFS_PLL_CLOCK_CONTROL |->
		##2 third_system_clock_rate == $past(reg_wdata[0], 2);
	endproperty
	a_rate: assert property (p_rate) else $error("third clock rate wrong");
endmodule
bind rcr_ctrl rcr_ctrl_chk u_chk (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
	.rec_left_out, .rec_right_out, .rec_out_valid, .input_gain_left,
	.record_converter_off, .record_analog_off, .reference_buffer_off, .record_master_en,
	.master_out_en, .pll_ref_en, .third_clock_from_receiver, .third_system_clock_rate);

// >>> dv/rcr_host.sv
`timescale 1ns/1ps
module rcr_host (
	input  wire logic       mclk,
	output logic      [6:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd,
	input  wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Released data is inverted so a late capture cannot pass on stale bits.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(negedge mclk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(negedge mclk);
		reg_rd <= 1'b0;
		d = reg_rdata;
	endtask
endmodule

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic        mclk, reset_n, reg_wr, reg_rd, rec_out_valid, sv;
	logic [6:0]  reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, d;
	logic [15:0] sl, sr, rec_left_out, rec_right_out;
	logic [5:0]  input_gain_left, input_gain_right;
	logic        highpass_enable, record_converter_off, record_analog_off;
	logic        gain_stage_left_off, gain_stage_right_off, reference_buffer_off;
	logic        record_master_en, modulator_clock_en, master_out_en, pll_ref_en;
	logic        third_clock_from_receiver, third_system_clock_rate;
	logic        second_synth_off, first_synth_off, oscillator_off;
	int          err_total, checked;
	logic [6:0]  ofs [11] = '{7'h6A, 7'h6B, 7'h6C, 7'h6D, 7'h6E, 7'h6F, 7'h70, 7'h71,
		7'h72, 7'h73, 7'h74};
	logic [7:0]  rst [11] = '{8'h3F, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
		8'h3F, 8'h3F, 8'h00};
	logic [7:0]  wex [11] = '{8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'h13, 8'hFF, 8'hFF,
		8'h3F, 8'h3F, 8'hFF};
	logic [5:0]  gc [5] = '{6'h01, 6'h2F, 6'h30, 6'h31, 6'h3F};
	int          dv [4] = '{1, 2, 3, 1};
	rcr_host host (.mclk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
	rcr_ctrl dut (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.play_left_sample(sl), .play_right_sample(sr), .play_sample_valid(sv),
		.rec_left_sample(sl), .rec_right_sample(sr), .rec_sample_valid(sv),
		.rec_left_out, .rec_right_out, .rec_out_valid, .input_gain_left, .input_gain_right,
		.highpass_enable, .record_converter_off, .record_analog_off, .gain_stage_left_off,
		.gain_stage_right_off, .reference_buffer_off, .record_master_en, .modulator_clock_en,
		.master_out_en, .pll_ref_en, .third_clock_from_receiver, .third_system_clock_rate,
		.second_synth_off, .first_synth_off, .oscillator_off);
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic rc(input logic [6:0] a, input logic [7:0] e);
		host.rd(a, d);
		chk({8'h00, e}, {8'h00, d});
	endtask
	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return record_master_en;
			1: return modulator_clock_en;
			2: return master_out_en;
			default: return pll_ref_en;
		endcase
	endfunction
	// Measures cycles between enable pulses; bounded so an enable stuck low ends the run.
	task automatic per(input int s, input int e);
		int m;
		m = 0;
		while (pick(s) !== 1'b1 && m < 50) begin
			@(negedge mclk);
			m++;
		end
		m = 0;
		do begin
			@(negedge mclk);
			m++;
		end while (pick(s) !== 1'b1 && m < 50);
		chk(16'(e), 16'(m));
		if (m >= 50) begin
			err_total++;
			complete_run();
		end
	endtask
	task automatic send(input logic [15:0] l, input logic [15:0] r);
		@(negedge mclk);
		sl <= l;
		sr <= r;
		sv <= 1'b1;
		@(negedge mclk);
		chk(16'h0001, {15'h0000, rec_out_valid});
		sv <= 1'b0;
		sl <= ~l;
		sr <= ~r;
		repeat (3) @(negedge mclk);
		chk(16'h0000, {15'h0000, rec_out_valid});
	endtask
	initial begin
		reset_n = 1'b0;
		sl = 16'h0000;
		sr = 16'h0000;
		sv = 1'b0;
		repeat (10) @(negedge mclk);
		reset_n = 1'b1;
		for (int i = 0; i < 11; i++)
			rc(ofs[i], rst[i]);
		for (int i = 0; i < 11; i++)
			host.wr(ofs[i], 8'hFF);
		for (int i = 0; i < 11; i++)
			rc(ofs[i], wex[i]);
		rc(7'h00, 8'h00);
		rc(7'h75, 8'h00);
		chk(16'h07FF, {5'h00, record_converter_off, record_analog_off,
			reference_buffer_off, third_clock_from_receiver, third_system_clock_rate,
			second_synth_off, first_synth_off, oscillator_off, highpass_enable,
			gain_stage_left_off, gain_stage_right_off});
		host.wr(7'h6E, 8'h10);
		repeat (2) @(negedge mclk);
		chk(16'h0001, {14'h0000, record_converter_off, record_analog_off});
		for (int i = 0; i < 5; i++) begin
			host.wr(7'h6D, {2'h0, gc[i]});
			repeat (2) @(negedge mclk);
			chk((gc[i] > 6'h30) ? 16'h30 : 16'(gc[i]), 16'(input_gain_right));
		end
		$display("registers done");
		for (int i = 0; i < 4; i++) begin
			host.wr(7'h6F, 8'(i));
			for (int j = 0; j < 2; j++) begin
				host.wr(7'h6E, 8'(j << 7));
				repeat (4) @(negedge mclk);
				per(0, dv[i]);
				per(1, dv[i] * (j ? 4 : 2));
			end
		end
		host.wr(7'h74, 8'h70);
		repeat (4) @(negedge mclk);
		chk(16'h0, {15'h0, third_clock_from_receiver});
		per(2, 2);
		per(3, 2);
		host.wr(7'h74, 8'h80);
		repeat (4) @(negedge mclk);
		chk(16'h0000, {14'h0000, third_clock_from_receiver, third_system_clock_rate});
		per(2, 1);
		per(3, 1);
		$display("clocks done");
		host.wr(7'h6E, 8'h04);
		host.wr(7'h71, 8'h7F);
		repeat (8) @(negedge mclk);
		send(16'h7FFF, 16'h4000);
		chk(16'h0000, rec_left_out);
		chk(16'h2000, rec_right_out);
		host.wr(7'h6E, 8'h00);
		host.wr(7'h70, 8'h00);
		repeat (8) @(negedge mclk);
		send(16'h4000, 16'hC000);
		chk(16'h0040, rec_left_out);
		chk(16'hE000, rec_right_out);
		host.wr(7'h70, 8'hFF);
		for (int i = 0; i < 4; i++)
			host.rd(ofs[(i < 2) ? i : i + 6], d);
		send(16'h7FFF, 16'h0000);
		chk(16'h7FFF, rec_left_out);
		rc(7'h6A, 8'h00);
		rc(7'h6B, 8'h3F);
		rc(7'h72, 8'h00);
		rc(7'h73, 8'h3F);
		rc(7'h72, 8'h3F);
		$display("datapath done");
		complete_run();
	end
endmodule

// >>> src/rcr_ctrl.sv
`timescale 1ns/1ps
module rcr_ctrl (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [6:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic [15:0] play_left_sample,
	input  wire logic [15:0] play_right_sample,
	input  wire logic        play_sample_valid,
	input  wire logic [15:0] rec_left_sample,
	input  wire logic [15:0] rec_right_sample,
	input  wire logic        rec_sample_valid,
	output logic      [15:0] rec_left_out,
	output logic      [15:0] rec_right_out,
	output logic             rec_out_valid,
	output logic      [5:0]  input_gain_left,
	output logic      [5:0]  input_gain_right,
	output logic             highpass_enable,
	output logic             record_converter_off,
	output logic             record_analog_off,
	output logic             gain_stage_left_off,
	output logic             gain_stage_right_off,
	output logic             reference_buffer_off,
	output logic             record_master_en,
	output logic             modulator_clock_en,
	output logic             master_out_en,
	output logic             pll_ref_en,
	output logic             third_clock_from_receiver,
	output logic             third_system_clock_rate,
	output logic             second_synth_off,
	output logic             first_synth_off,
	output logic             oscillator_off
);

	// Maps an address to a writable register; used for write and read decode.
	function automatic logic [3:0] rcr_rw_index(input logic [6:0] addr);
		case (addr)
			rcr_pkg::OFS_ADC_LEFT_GAIN:       rcr_rw_index = {1'b1, rcr_pkg::IDX_GAIN_LEFT};
			rcr_pkg::OFS_ADC_RIGHT_GAIN:      rcr_rw_index = {1'b1, rcr_pkg::IDX_GAIN_RIGHT};
			rcr_pkg::OFS_RECORD_CONTROL_ONE:  rcr_rw_index = {1'b1, rcr_pkg::IDX_CONTROL_ONE};
			rcr_pkg::OFS_RECORD_CONTROL_TWO:  rcr_rw_index = {1'b1, rcr_pkg::IDX_CONTROL_TWO};
			rcr_pkg::OFS_RECORD_LEFT_VOLUME:  rcr_rw_index = {1'b1, rcr_pkg::IDX_VOL_LEFT};
			rcr_pkg::OFS_RECORD_RIGHT_VOLUME: rcr_rw_index = {1'b1, rcr_pkg::IDX_VOL_RIGHT};
			rcr_pkg::OFS_PLL_CLOCK_CONTROL:   rcr_rw_index = {1'b1, rcr_pkg::IDX_PLL};
			default:                          rcr_rw_index = 4'h0;
		endcase
	endfunction

	function automatic logic [5:0] rcr_clamp_gain(input logic [7:0] code);
		if (code[5:0] > rcr_pkg::GAIN_CODE_MAX) begin
			rcr_clamp_gain = rcr_pkg::GAIN_CODE_MAX;
		end else begin
			rcr_clamp_gain = code[5:0];
		end
	endfunction

	// Gain is (code + 1) / 256, so all ones is exactly unity.
	function automatic logic [15:0] rcr_scale(input logic [15:0] s, input logic [7:0] vol);
		logic signed [25:0] prod;
		prod = $signed(s) * $signed({1'b0, {1'b0, vol} + 9'h001});
		rcr_scale = prod[23:8];
	endfunction

	localparam logic [6:0] PEAK_OFS [rcr_pkg::NUM_PEAK] = '{
		rcr_pkg::OFS_PLAYBACK_LEFT_PEAK, rcr_pkg::OFS_DAC_RIGHT_PEAK,
		rcr_pkg::OFS_RECORD_LEFT_PEAK, rcr_pkg::OFS_RECORD_RIGHT_PEAK
	};
	localparam logic [7:0] RW_MASK [rcr_pkg::NUM_RW] = '{
		rcr_pkg::MASK_GAIN, rcr_pkg::MASK_GAIN, rcr_pkg::MASK_CONTROL_ONE,
		rcr_pkg::MASK_CONTROL_TWO, rcr_pkg::MASK_VOLUME, rcr_pkg::MASK_VOLUME,
		rcr_pkg::MASK_PLL
	};
	localparam logic [7:0] RW_RESET [rcr_pkg::NUM_RW] = '{
		rcr_pkg::RST_GAIN, rcr_pkg::RST_GAIN, rcr_pkg::RST_CONTROL_ONE,
		rcr_pkg::RST_CONTROL_TWO, rcr_pkg::RST_VOLUME, rcr_pkg::RST_VOLUME,
		rcr_pkg::RST_PLL
	};

	logic [7:0]  regs      [rcr_pkg::NUM_RW];
	logic [7:0]  next_regs [rcr_pkg::NUM_RW];
	logic [15:0] peak_sample [rcr_pkg::NUM_PEAK];
	logic        peak_valid  [rcr_pkg::NUM_PEAK];
	logic [5:0]  peak_code   [rcr_pkg::NUM_PEAK];
	logic        peak_clear  [rcr_pkg::NUM_PEAK];
	logic [3:0]  wr_hit;
	logic [3:0]  rd_hit;
	logic [7:0]  next_reg_rdata;
	logic [7:0]  ctl_one;
	logic [7:0]  ctl_two;
	logic [7:0]  pll_ctl;
	logic [15:0] rec_left_scaled;
	logic [15:0] rec_right_scaled;
	logic [15:0] next_rec_left_out;
	logic [15:0] next_rec_right_out;
	logic [1:0]  master_cnt;
	logic [1:0]  next_master_cnt;
	logic [1:0]  master_last;
	logic        next_record_master_en;
	logic [1:0]  mod_cnt;
	logic [1:0]  next_mod_cnt;
	logic [1:0]  mod_last;
	logic        next_modulator_clock_en;
	logic        out_phase;
	logic        ref_phase;
	logic        next_master_out_en;
	logic        next_pll_ref_en;

	assign ctl_one = regs[rcr_pkg::IDX_CONTROL_ONE];
	assign ctl_two = regs[rcr_pkg::IDX_CONTROL_TWO];
	assign pll_ctl = regs[rcr_pkg::IDX_PLL];

	// Register access and read-back.
	always_comb begin
		wr_hit = rcr_rw_index(reg_addr);
		rd_hit = rcr_rw_index(reg_addr);
		for (int i = 0; i < rcr_pkg::NUM_RW; i++) begin
			next_regs[i] = regs[i];
		end
		if (reg_wr && wr_hit[3]) begin
			next_regs[wr_hit[2:0]] = reg_wdata & RW_MASK[wr_hit[2:0]];
		end
		next_reg_rdata = reg_rdata;
		if (reg_rd) begin
			next_reg_rdata = 8'h00;
			if (rd_hit[3]) begin
				next_reg_rdata = regs[rd_hit[2:0]];
			end
			for (int p = 0; p < rcr_pkg::NUM_PEAK; p++) begin
				if (reg_addr == PEAK_OFS[p]) begin
					next_reg_rdata = {2'h0, peak_code[p]};
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < rcr_pkg::NUM_RW; i++) begin
				regs[i] <= RW_RESET[i];
			end
			reg_rdata <= 8'h00;
		end else begin
			regs      <= next_regs;
			reg_rdata <= next_reg_rdata;
		end
	end

	// Peak detectors; reading a peak register restarts its hold.
	assign peak_sample[0] = play_left_sample;
	assign peak_sample[1] = play_right_sample;
	assign peak_sample[2] = next_rec_left_out;
	assign peak_sample[3] = next_rec_right_out;
	assign peak_valid[0]  = play_sample_valid;
	assign peak_valid[1]  = play_sample_valid;
	assign peak_valid[2]  = rec_sample_valid;
	assign peak_valid[3]  = rec_sample_valid;

	generate
		for (genvar g = 0; g < rcr_pkg::NUM_PEAK; g++) begin : gen_peak
			assign peak_clear[g] = reg_rd && (reg_addr == PEAK_OFS[g]);
			rcr_peak_meter u_meter (
				.mclk         (mclk),
				.reset_n      (reset_n),
				.sample       (peak_sample[g]),
				.sample_valid (peak_valid[g]),
				.clear        (peak_clear[g]),
				.level_code   (peak_code[g])
			);
		end
	endgenerate

	// Record datapath: volume then mute.
	always_comb begin
		rec_left_scaled  = rcr_scale(rec_left_sample, regs[rcr_pkg::IDX_VOL_LEFT]);
		rec_right_scaled = rcr_scale(rec_right_sample, regs[rcr_pkg::IDX_VOL_RIGHT]);
		next_rec_left_out  = rec_left_out;
		next_rec_right_out = rec_right_out;
		if (rec_sample_valid) begin
			next_rec_left_out  = ctl_one[rcr_pkg::POS_RECORD_MUTE_LEFT] ?
				16'h0000 : rec_left_scaled;
			next_rec_right_out = ctl_one[rcr_pkg::POS_RECORD_MUTE_RIGHT] ?
				16'h0000 : rec_right_scaled;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rec_left_out  <= 16'h0000;
			rec_right_out <= 16'h0000;
			rec_out_valid <= 1'b0;
		end else begin
			rec_left_out  <= next_rec_left_out;
			rec_right_out <= next_rec_right_out;
			rec_out_valid <= rec_sample_valid;
		end
	end

	// Clock enables; each divided rate is a single-cycle pulse on mclk, and an undivided rate holds its enable high.
	always_comb begin
		case (ctl_two[rcr_pkg::POS_RECORD_CLOCK_DIV +: 2])
			rcr_pkg::RECORD_DIV_TWO:   master_last = 2'h1;
			rcr_pkg::RECORD_DIV_THREE: master_last = 2'h2;
			default:                   master_last = 2'h0;
		endcase
		// A shortened divide mid-count restarts at once instead of wrapping.
		if (master_cnt >= master_last) begin
			next_master_cnt = 2'h0;
			next_record_master_en = 1'b1;
		end else begin
			next_master_cnt = master_cnt + 2'h1;
			next_record_master_en = 1'b0;
		end
		mod_last = ctl_one[rcr_pkg::POS_MODULATOR_CLOCK_RATIO] ?
			rcr_pkg::MOD_LAST_QUARTER : rcr_pkg::MOD_LAST_HALF;
		next_mod_cnt = mod_cnt;
		next_modulator_clock_en = 1'b0;
		if (next_record_master_en) begin
			if (mod_cnt >= mod_last) begin
				next_mod_cnt = 2'h0;
				next_modulator_clock_en = 1'b1;
			end else begin
				next_mod_cnt = mod_cnt + 2'h1;
			end
		end
		next_master_out_en = pll_ctl[rcr_pkg::POS_MASTER_OUT_HALVE] ? ~out_phase : 1'b1;
		next_pll_ref_en = pll_ctl[rcr_pkg::POS_CRYSTAL_PREHALVE] ? ~ref_phase : 1'b1;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			master_cnt         <= 2'h0;
			mod_cnt            <= 2'h0;
			out_phase          <= 1'b0;
			ref_phase          <= 1'b0;
			record_master_en   <= 1'b0;
			modulator_clock_en <= 1'b0;
			master_out_en      <= 1'b0;
			pll_ref_en         <= 1'b0;
		end else begin
			master_cnt         <= next_master_cnt;
			mod_cnt            <= next_mod_cnt;
			out_phase          <= next_master_out_en;
			ref_phase          <= next_pll_ref_en;
			record_master_en   <= next_record_master_en;
			modulator_clock_en <= next_modulator_clock_en;
			master_out_en      <= next_master_out_en;
			pll_ref_en         <= next_pll_ref_en;
		end
	end

	// Static control outputs, registered one cycle after the register.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			input_gain_left           <= 6'h00;
			input_gain_right          <= 6'h00;
			highpass_enable           <= 1'b0;
			record_converter_off      <= 1'b0;
			record_analog_off         <= 1'b0;
			gain_stage_left_off       <= 1'b0;
			gain_stage_right_off      <= 1'b0;
			reference_buffer_off      <= 1'b0;
			third_clock_from_receiver <= 1'b0;
			third_system_clock_rate   <= 1'b0;
			second_synth_off          <= 1'b0;
			first_synth_off           <= 1'b0;
			oscillator_off            <= 1'b0;
		end else begin
			input_gain_left      <= rcr_clamp_gain(regs[rcr_pkg::IDX_GAIN_LEFT]);
			input_gain_right     <= rcr_clamp_gain(regs[rcr_pkg::IDX_GAIN_RIGHT]);
			highpass_enable      <= ctl_one[rcr_pkg::POS_HIGHPASS_ENABLE];
			record_converter_off <= ctl_one[rcr_pkg::POS_RECORD_CONVERTER_OFF];
			record_analog_off    <= ctl_one[rcr_pkg::POS_RECORD_ANALOG_OFF];
			gain_stage_left_off  <= ctl_one[rcr_pkg::POS_GAIN_STAGE_LEFT_OFF];
			gain_stage_right_off <= ctl_one[rcr_pkg::POS_GAIN_STAGE_RIGHT_OFF];
			reference_buffer_off <= ctl_two[rcr_pkg::POS_REFERENCE_BUFFER_OFF];
			// Reserved route codes fall back to the PLL source.
			third_clock_from_receiver <= (pll_ctl[rcr_pkg::POS_RECOVERED_CLOCK_ROUTE +: 2]
				== rcr_pkg::ROUTE_FROM_RECEIVER);
			third_system_clock_rate <= pll_ctl[rcr_pkg::POS_THIRD_SYSTEM_CLOCK_RATE];
			second_synth_off <= pll_ctl[rcr_pkg::POS_SECOND_SYNTH_OFF];
			first_synth_off  <= pll_ctl[rcr_pkg::POS_FIRST_SYNTH_OFF];
			oscillator_off   <= pll_ctl[rcr_pkg::POS_OSCILLATOR_OFF];
		end
	end

endmodule

// >>> src/rcr_peak_meter.sv
`timescale 1ns/1ps
module rcr_peak_meter (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic [15:0] sample,
	input  wire logic        sample_valid,
	input  wire logic        clear,
	output logic      [5:0]  level_code
);

	logic [14:0] hold;
	logic [14:0] next_hold;
	logic [5:0]  next_level_code;
	logic [14:0] mag;
	logic [14:0] base;
	logic [14:0] shifted;
	logic [3:0]  pos;
	logic        found;
	logic [2:0]  sub;
	logic [6:0]  whole;

	always_comb begin
		// The most negative sample saturates rather than wrapping to zero.
		if (!sample[15]) begin
			mag = sample[14:0];
		end else if (sample[14:0] == 15'h0000) begin
			mag = 15'h7FFF;
		end else begin
			mag = 15'(~sample[14:0] + 15'h0001);
		end
		// A sample in the clearing cycle starts the new hold so it is not lost.
		base = clear ? 15'h0000 : hold;
		next_hold = base;
		if (sample_valid && mag > base) begin
			next_hold = mag;
		end
		found = 1'b0;
		pos = 4'h0;
		for (int i = 14; i >= 0; i--) begin
			if (!found && hold[i]) begin
				found = 1'b1;
				pos = 4'(i);
			end
		end
		shifted = hold << (4'hE - pos);
		case (shifted[13:12])
			2'h3: sub = 3'h0;
			2'h2: sub = 3'h2;
			2'h1: sub = 3'h3;
			default: sub = 3'h5;
		endcase
		// Roughly six steps of one dB per bit of magnitude, refined by two bits.
		whole = 7'(7'h06 * {3'h0, 4'hE - pos}) + {4'h0, sub};
		if (!found || whole > {1'b0, rcr_pkg::LEVEL_CODE_FLOOR}) begin
			next_level_code = rcr_pkg::LEVEL_CODE_FLOOR;
		end else begin
			next_level_code = whole[5:0];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hold       <= 15'h0000;
			level_code <= rcr_pkg::LEVEL_CODE_FLOOR;
		end else begin
			hold       <= next_hold;
			level_code <= next_level_code;
		end
	end

endmodule

// >>> src/rcr_pkg.sv
package rcr_pkg;

	localparam int unsigned ADDR_W   = 7;
	localparam int unsigned DATA_W   = 8;
	localparam int unsigned SAMPLE_W = 16;
	localparam int unsigned LEVEL_W  = 6;
	localparam int unsigned NUM_RW   = 7;
	localparam int unsigned NUM_PEAK = 4;

	// Register offsets.
	localparam logic [6:0] OFS_PLAYBACK_LEFT_PEAK  = 7'h6A;
	localparam logic [6:0] OFS_DAC_RIGHT_PEAK      = 7'h6B;
	localparam logic [6:0] OFS_ADC_LEFT_GAIN       = 7'h6C;
	localparam logic [6:0] OFS_ADC_RIGHT_GAIN      = 7'h6D;
	localparam logic [6:0] OFS_RECORD_CONTROL_ONE  = 7'h6E;
	localparam logic [6:0] OFS_RECORD_CONTROL_TWO  = 7'h6F;
	localparam logic [6:0] OFS_RECORD_LEFT_VOLUME  = 7'h70;
	localparam logic [6:0] OFS_RECORD_RIGHT_VOLUME = 7'h71;
	localparam logic [6:0] OFS_RECORD_LEFT_PEAK    = 7'h72;
	localparam logic [6:0] OFS_RECORD_RIGHT_PEAK   = 7'h73;
	localparam logic [6:0] OFS_PLL_CLOCK_CONTROL   = 7'h74;

	// Index of each writable register in the storage array.
	localparam logic [2:0] IDX_GAIN_LEFT   = 3'h0;
	localparam logic [2:0] IDX_GAIN_RIGHT  = 3'h1;
	localparam logic [2:0] IDX_CONTROL_ONE = 3'h2;
	localparam logic [2:0] IDX_CONTROL_TWO = 3'h3;
	localparam logic [2:0] IDX_VOL_LEFT    = 3'h4;
	localparam logic [2:0] IDX_VOL_RIGHT   = 3'h5;
	localparam logic [2:0] IDX_PLL         = 3'h6;

	// Record control one fields.
	localparam int unsigned POS_MODULATOR_CLOCK_RATIO = 7;
	localparam int unsigned POS_HIGHPASS_ENABLE       = 6;
	localparam int unsigned POS_RECORD_CONVERTER_OFF  = 5;
	localparam int unsigned POS_RECORD_ANALOG_OFF     = 4;
	localparam int unsigned POS_RECORD_MUTE_RIGHT     = 3;
	localparam int unsigned POS_RECORD_MUTE_LEFT      = 2;
	localparam int unsigned POS_GAIN_STAGE_LEFT_OFF   = 1;
	localparam int unsigned POS_GAIN_STAGE_RIGHT_OFF  = 0;

	// Record control two fields.
	localparam int unsigned POS_REFERENCE_BUFFER_OFF = 4;
	localparam int unsigned POS_RECORD_CLOCK_DIV     = 0;

	// PLL clock control one fields.
	localparam int unsigned POS_RECOVERED_CLOCK_ROUTE   = 6;
	localparam int unsigned POS_MASTER_OUT_HALVE        = 5;
	localparam int unsigned POS_CRYSTAL_PREHALVE        = 4;
	localparam int unsigned POS_SECOND_SYNTH_OFF        = 3;
	localparam int unsigned POS_FIRST_SYNTH_OFF         = 2;
	localparam int unsigned POS_OSCILLATOR_OFF          = 1;
	localparam int unsigned POS_THIRD_SYSTEM_CLOCK_RATE = 0;

	// Writable bits of each register; reserved bits stay zero.
	localparam logic [7:0] MASK_GAIN        = 8'h3F;
	localparam logic [7:0] MASK_CONTROL_ONE = 8'hFF;
	localparam logic [7:0] MASK_CONTROL_TWO = 8'h13;
	localparam logic [7:0] MASK_VOLUME      = 8'hFF;
	localparam logic [7:0] MASK_PLL         = 8'hFF;

	// Reset values.
	localparam logic [7:0] RST_GAIN        = 8'h00;
	localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
	localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
	localparam logic [7:0] RST_VOLUME      = 8'hFF;
	localparam logic [7:0] RST_PLL         = 8'h00;

	localparam logic [5:0] GAIN_CODE_MAX    = 6'h30;
	localparam logic [5:0] LEVEL_CODE_FLOOR = 6'h3F;

	localparam logic [1:0] RECORD_DIV_ONE      = 2'h0;
	localparam logic [1:0] RECORD_DIV_TWO      = 2'h1;
	localparam logic [1:0] RECORD_DIV_THREE    = 2'h2;
	localparam logic [1:0] ROUTE_FROM_RECEIVER = 2'h3;

	// Modulator divide, counted in record master clock enables.
	localparam logic [1:0] MOD_LAST_HALF    = 2'h1;
	localparam logic [1:0] MOD_LAST_QUARTER = 2'h3;

endpackage
